/* File: sam_alarm_manager.v */
/*
 Servo alarm manager: latches faults, drives the active-low alarm and
 code outputs, keeps a ten-entry history and gates motion.
 Assumes external inputs are asynchronous pins; the panel command and
 fault strobes come from logic on clk.
*/
`timescale 1ns/1ps
`include "sam_defines.vh"

module sam_alarm_manager #(
	parameter TRIP_CYCLES = (`SAM_TRIP_MS * `SAM_CLK_KHZ),
	parameter DEPTH       = `SAM_HIST_DEPTH
) (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire                   powerUp,
	input  wire                   alarmResetIn,
	input  wire                   runIn,
	input  wire                   fwdTravelLimit,
	input  wire                   revTravelLimit,
	input  wire                   positionErrorClear,
	input  wire                   positionLockInput,
	input  wire                   positionMode,
	input  wire [7:0]             servoSetupWord,
	input  wire                   faultValid,
	input  wire [`SAM_CODE_W-1:0] faultCode,
	input  wire [`SAM_LOAD_W-1:0] loadPct,
	input  wire                   panelReset,
	input  wire                   keyUp,
	input  wire                   keyDown,
	input  wire                   keyModeSet,
	input  wire [7:0]             systemCheckParam,
	input  wire [7:0]             paramData,
	input  wire                   paramEditing,
	output reg                    alarmOutN,
	output reg  [2:0]             alarmCodeOut,
	output reg                    driveEnable,
	output reg                    motionAllowed,
	output reg                    alarmActive,
	output reg  [`SAM_CODE_W-1:0] displayCode,
	output reg                    historyMode,
	output reg  [`SAM_IDX_W-1:0]  historyIndex,
	output reg  [`SAM_CODE_W-1:0] historyCode
);
	localparam ST_NORMAL = 2'h0;
	localparam ST_ALARM  = 2'h1;
	localparam ST_HOLD   = 2'h2;

	// Pin synchronisers
	reg  [6:0] syncA;
	reg  [6:0] syncB;
	wire [6:0] pins = {alarmResetIn, runIn, fwdTravelLimit, revTravelLimit,
	                   positionErrorClear, positionLockInput, powerUp};
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			syncA <= 7'h0;
			syncB <= 7'h0;
		end else begin
			syncA <= pins;
			syncB <= syncA;
		end
	end
	wire rstSync   = syncB[6];
	wire runSync   = syncB[5];
	wire fwdOk     = syncB[4];
	wire revOk     = syncB[3];
	wire ecrSync   = syncB[2];
	wire lockSync  = syncB[1];
	wire powerSync = syncB[0];

	reg rstPrev;
	reg powerPrev;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstPrev   <= 1'b0;
			powerPrev <= 1'b0;
		end else begin
			rstPrev   <= rstSync;
			powerPrev <= powerSync;
		end
	end
	wire rstRise   = rstSync & ~rstPrev;
	wire powerRise = powerSync & ~powerPrev;

	// Overload integrator
	wire ovlTrip;
	wire ovlHigh;
	reg  clearNow;
	sam_overload #(
		.TRIP_CYCLES (TRIP_CYCLES)
	) uOverload (
		.clk      (clk),
		.rstn     (rstn),
		.loadPct  (loadPct),
		.clear    (clearNow),
		.trip     (ovlTrip),
		.tripHigh (ovlHigh)
	);
	reg ovlPrev;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			ovlPrev <= 1'b0;
		else
			ovlPrev <= ovlTrip;
	end
	wire ovlEvent = ovlTrip & ~ovlPrev;

	wire                   newFault = faultValid | ovlEvent;
	wire [`SAM_CODE_W-1:0] newCode  = faultValid ? faultCode :
		(ovlHigh ? `SAM_CODE_OVL_HIGH : `SAM_CODE_OVL_LOW);

	// Latched alarm and clearing
	reg [1:0]             state;
	reg [1:0]             next_state;
	reg [`SAM_CODE_W-1:0] latchedCode;
	wire isOvercur   = latchedCode == `SAM_CODE_OVERCUR;
	wire clearByPin  = rstRise | panelReset;
	wire clearByPwr  = powerRise & ~isOvercur;
	wire histErase   = keyModeSet & paramEditing &
	                   (systemCheckParam == `SAM_SYSCHK_PARAM) &
	                   (paramData == `SAM_SYSCHK_CLRHIST);

	always @* begin
		next_state = state;
		clearNow   = 1'b0;
		case (state)
			ST_NORMAL: begin
				if (newFault)
					next_state = rstSync ? ST_HOLD : ST_ALARM;
			end
			ST_ALARM: begin
				if (clearByPin | clearByPwr) begin
					next_state = ST_NORMAL;
					clearNow   = 1'b1;
				end
			end
			ST_HOLD: begin
				// Reset input must first go low before a clear counts
				if (!rstSync)
					next_state = ST_ALARM;
			end
			default: next_state = ST_NORMAL;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state       <= ST_NORMAL;
			latchedCode <= `SAM_CODE_NONE;
		end else begin
			state <= next_state;
			if (state == ST_NORMAL && newFault)
				latchedCode <= newCode;
			else if (clearNow)
				latchedCode <= `SAM_CODE_NONE;
		end
	end

	function [2:0] codeGroup;
		input [`SAM_CODE_W-1:0] c;
		begin
			if (c == `SAM_CODE_OVERCUR)
				codeGroup = `SAM_ALO_OVERCUR;
			else if (c == `SAM_CODE_OVL_HIGH || c == `SAM_CODE_OVL_LOW)
				codeGroup = `SAM_ALO_OVERLOAD;
			else
				codeGroup = `SAM_ALO_OTHER;
		end
	endfunction

	// Motion gating
	wire alarmNow  = next_state != ST_NORMAL;
	wire servoOn   = servoSetupWord[`SAM_BIT_ALWAYS_ON] | runSync;
	wire limitsOk  = (fwdOk | servoSetupWord[`SAM_BIT_FWD_IGNORE]) &
	                 (revOk | servoSetupWord[`SAM_BIT_REV_IGNORE]);
	wire holdPos   = positionMode & ecrSync;
	wire holdSpeed = ~positionMode & lockSync;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarmOutN     <= 1'b0;
			alarmCodeOut  <= 3'h0;
			driveEnable   <= 1'b0;
			motionAllowed <= 1'b0;
			alarmActive   <= 1'b0;
			displayCode   <= `SAM_CODE_NONE;
		end else begin
			alarmOutN     <= ~alarmNow;
			alarmCodeOut  <= alarmNow ?
				codeGroup((state == ST_NORMAL) ? newCode : latchedCode) : 3'h0;
			driveEnable   <= ~alarmNow & servoOn;
			motionAllowed <= ~alarmNow & servoOn & limitsOk & ~holdPos & ~holdSpeed;
			alarmActive   <= alarmNow;
			displayCode   <= (state == ST_NORMAL) ?
				(newFault ? newCode : `SAM_CODE_NONE) : latchedCode;
		end
	end

	// History: entry 0 newest, shift-in drops the oldest
	reg  [`SAM_CODE_W-1:0] hist [0:DEPTH-1];
	reg  [`SAM_IDX_W-1:0]  histCount;
	wire faultPush = state == ST_NORMAL && newFault;
	wire markPush  = clearNow | powerRise;
	wire histPush  = faultPush | markPush;
	wire [`SAM_CODE_W-1:0] pushCode = faultPush ? newCode : `SAM_CODE_RESET_MARK;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : gHist
			always @(posedge clk or negedge rstn) begin
				if (!rstn)
					hist[gi] <= `SAM_CODE_NONE;
				else if (histErase)
					hist[gi] <= (gi == 0 && histPush) ? pushCode : `SAM_CODE_NONE;
				else if (histPush) begin
					if (gi == 0)
						hist[gi] <= pushCode;
					else
						hist[gi] <= hist[gi-1];
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			histCount <= {`SAM_IDX_W{1'b0}};
		else if (histErase)
			histCount <= {{(`SAM_IDX_W-1){1'b0}}, histPush};
		else if (histPush && histCount != DEPTH[`SAM_IDX_W-1:0])
			histCount <= histCount + 1'b1;
	end

	// Panel paging; mode key toggles history display
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			historyMode  <= 1'b0;
			historyIndex <= {`SAM_IDX_W{1'b0}};
			historyCode  <= `SAM_CODE_NONE;
		end else begin
			if (keyModeSet && !paramEditing) begin
				historyMode  <= ~historyMode;
				historyIndex <= {`SAM_IDX_W{1'b0}};
			end else if (historyMode && keyUp &&
			             historyIndex != DEPTH[`SAM_IDX_W-1:0] - 1'b1)
				historyIndex <= historyIndex + 1'b1;
			else if (historyMode && keyDown && historyIndex != {`SAM_IDX_W{1'b0}})
				historyIndex <= historyIndex - 1'b1;
			historyCode <= (historyIndex < histCount) ? hist[historyIndex] : `SAM_CODE_NONE;
		end
	end
endmodule // sam_alarm_manager

/* File: sam_alarm_manager_checker.sv */
/* Checker for the alarm manager: alarm, drive and history index relations.
 Assumes it is bound into every alarm manager instance. */
`timescale 1ns/1ps
module sam_alarm_manager_checker (
	input wire       clk,
	input wire       rstn,
	input wire       faultValid,
	input wire [7:0] faultCode,
	input wire       panelReset,
	input wire       alarmResetIn,
	input wire [7:0] servoSetupWord,
	input wire       fwdTravelLimit,
	input wire       alarmOutN,
	input wire [2:0] alarmCodeOut,
	input wire       driveEnable,
	input wire       motionAllowed,
	input wire       alarmActive,
	input wire [3:0] historyIndex
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// The first edge after release still sees the reset levels
	a_out_level: assert property ($past(rstn) |-> alarmOutN != alarmActive)
		else $error("alarm output level wrong");
	a_fault_raise: assert property (faultValid && alarmOutN |=> alarmActive && !alarmOutN)
		else $error("fault not latched");
	a_oc_code: assert property (
		faultValid && alarmOutN && faultCode == 8'h10 |=> alarmCodeOut == 3'h1)
		else $error("overcurrent code wrong");
	a_drive_off: assert property (alarmActive |-> !driveEnable && !motionAllowed)
		else $error("drive on during alarm");
	a_panel_clear: assert property (
		alarmActive && panelReset && !alarmResetIn |=> !alarmActive)
		else $error("panel reset did not clear");
	// Six quiet cycles cover the pin synchroniser, so only power-up can act
	a_power_keep: assert property (
		(alarmActive && alarmCodeOut == 3'h1 && !panelReset && !alarmResetIn) [*6]
		|=> alarmActive)
		else $error("overcurrent alarm lost");
	a_always_on: assert property (
		(!alarmActive && servoSetupWord[0]) [*4] |-> driveEnable)
		else $error("always-on servo not driven");
	// Three samples of the pin cover the synchroniser and the output flop
	a_motion_gate: assert property (
		(!fwdTravelLimit && !servoSetupWord[2]) [*3] |=> !motionAllowed)
		else $error("motion past forward limit");
	a_index_range: assert property (historyIndex <= 4'h9)
		else $error("history index out of range");
endmodule // sam_alarm_manager_checker
bind sam_alarm_manager sam_alarm_manager_checker chk_u (.*);

/* File: sam_alarm_manager_test.sv */
/* Bench for the alarm manager: host model plus a reference history queue.
 Assumes the overload trip count is shortened to 100. */
`timescale 1ns/1ps
module sam_alarm_manager_test;
	logic        clk = 1'h0, rstn, powerUp, faultValid, panelReset, keyUp, keyDown;
	logic        keyModeSet, positionMode, paramEditing;
	logic [7:0]  faultCode, servoSetupWord, systemCheckParam, paramData;
	logic [8:0]  loadPct;
	wire         runIn, alarmResetIn, fwdTravelLimit, revTravelLimit, positionErrorClear;
	wire         positionLockInput, alarmOutN, driveEnable, motionAllowed, alarmActive;
	wire         historyMode;
	wire  [2:0]  alarmCodeOut;
	wire  [3:0]  historyIndex;
	wire  [7:0]  displayCode, historyCode;
	int          err_total = 0, samples_checked = 0, n, hist[$];
	bit          alarm_out_n;
	logic [31:0] v;
	sam_alarm_manager #(.TRIP_CYCLES(100)) dut_u (.*);
	sam_host_model host_u (.*);
	always #2.5 clk = ~clk;
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task push(input [7:0] c);
		hist.push_front(c);
		if (hist.size() > 10) hist.pop_back();
	endtask
	task key(input [2:0] k);
		{keyUp, keyDown, keyModeSet} = k;
		tick;
		{keyUp, keyDown, keyModeSet} = 3'h0;
		tick;
	endtask
	task fault(input [7:0] c);
		{faultCode, faultValid} = {c, 1'h1};
		tick;
		faultValid = 1'h0;
		chk(alarmOutN, 1'h0, "alarm out");
		chk(alarmCodeOut, c == 8'h10 ? 1 : (c == 8'h71 || c == 8'h72) ? 7 : 0, "code");
		push(c);
		alarm_out_n = 1'h1;
	endtask
	task clr;
		tick;
		panelReset = 1'h1;
		tick;
		panelReset = 1'h0;
		chk(alarmOutN, 1'h1, "panel clear");
		chk(driveEnable, runIn | servoSetupWord[0], "resume");
		push(8'h99);
		alarm_out_n = 1'h0;
	endtask
	task pwr(input e);
		powerUp = 1'h1;
		repeat (6) tick;
		powerUp = 1'h0;
		repeat (4) tick;
		push(8'h99);
		alarm_out_n = e;
		chk(alarmActive, e, "power");
	endtask
	task pinClr;
		host_u.pressReset(2);
		chk(alarmActive, 1'h1, "pin early");
		tick;
		chk(alarmActive, 1'h0, "pin clear");
		push(8'h99);
		alarm_out_n = 1'h0;
	endtask
	task readHist;
		key(3'h1);
		chk(historyMode, 1'h1, "enter");
		repeat (10) key(3'h2);
		for (int i = 0; i < 10; i++) begin
			chk(historyCode, i < hist.size() ? hist[i] : 0, "entry");
			key(3'h4);
		end
		chk(historyIndex, 4'h9, "index");
		key(3'h1);
		chk(historyMode, 1'h0, "leave");
	endtask
	task gate;
		v = $urandom;
		host_u.setPins(v[4:0]);
		{positionMode, servoSetupWord} = {v[8], 4'h0, v[7:6], 1'h0, v[5]};
		repeat (5) tick;
		chk(driveEnable, !alarm_out_n && (v[5] | v[4]), "drive");
		chk(motionAllowed, !alarm_out_n && (v[5] | v[4]) && (v[6] | v[3]) && (v[7] | v[2])
			&& !(v[8] ? v[1] : v[0]), "motion");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{powerUp, faultValid, panelReset, keyUp, keyDown, keyModeSet, positionMode} = 7'h0;
		{paramEditing, faultCode, loadPct, servoSetupWord, systemCheckParam, paramData} = 42'h0;
		{rstn, alarm_out_n} = 2'h0;
		v = $urandom(32'h032248a1);
		repeat (8) @(posedge clk);
		#1 rstn = 1'h1;
		repeat (4) tick;
		chk(alarmOutN, 1'h1, "idle");
		repeat (24) gate;
		host_u.setPins(5'h1c);
		servoSetupWord = 8'h0;
		fault(8'h10);
		pwr(1'h1);
		clr;
		fault(8'h40);
		pwr(1'h0);
		fault(8'h51);
		pinClr;
		// Pin must settle high before the fault, or its edge would clear it
		host_u.hold(1'h1);
		repeat (6) tick;
		fault(8'h72);
		host_u.hold(1'h0);
		repeat (6) tick;
		chk(alarmActive, 1'h1, "held");
		pinClr;
		repeat (12) begin
			v = $urandom;
			fault({v[7:1], 1'h1});
			clr;
		end
		readHist;
		{paramEditing, paramData} = {1'h1, 8'h02};
		key(3'h1);
		paramEditing = 1'h0;
		hist.delete();
		readHist;
		fault(8'h30);
		repeat (4) gate;
		clr;
		// Three times rated: trip count of 100 plus two cycles to the output
		loadPct = 9'h12c;
		for (n = 0; n < 400 && alarmActive !== 1'h1; n++) tick;
		chk(displayCode, 8'h71, "overload");
		chk(n >= 100 && n <= 105, 1'h1, "trip time");
		clr;
		loadPct = 9'h078;
		for (n = 0; n < 1100 && alarmActive !== 1'h1; n++) tick;
		chk(displayCode, 8'h72, "overload low");
		chk(n >= 1000 && n <= 1005, 1'h1, "slow trip");
		print_verdict;
	end
	initial begin
		#50000;
		err_total++;
		print_verdict;
	end
endmodule // sam_alarm_manager_test

/* File: sam_defines.vh */
/*
 Constants for the servo alarm manager: alarm codes, history size,
 setup-word bit positions, panel command values and overload timing.
 Included by the alarm manager and its overload integrator.
*/
`ifndef SAM_DEFINES_VH
`define SAM_DEFINES_VH

`define SAM_CODE_W          8
`define SAM_CODE_NONE       8'h00
`define SAM_CODE_OVERCUR    8'h10
`define SAM_CODE_OVL_HIGH   8'h71
`define SAM_CODE_OVL_LOW    8'h72
`define SAM_CODE_RESET_MARK 8'h99
`define SAM_ALO_OVERCUR     3'h1
`define SAM_ALO_OVERLOAD    3'h7
`define SAM_ALO_OTHER       3'h0
`define SAM_HIST_DEPTH      10
`define SAM_IDX_W           4
`define SAM_BIT_ALWAYS_ON   0
`define SAM_BIT_FWD_IGNORE  2
`define SAM_BIT_REV_IGNORE  3
`define SAM_SYSCHK_PARAM    8'h00
`define SAM_SYSCHK_CLRHIST  8'h02
`define SAM_TRIP_MS         3000
`define SAM_CLK_KHZ         200000
`define SAM_LOAD_W          9
`define SAM_RATED_LOAD      9'h064
`define SAM_MAX_LOAD        9'h1ff
`define SAM_HIGH_LOAD       9'h087
`define SAM_TRIP_EXCESS     48'd200

`endif

/* File: sam_host_model.sv */
/* Host controller model: drives run, reset, travel-limit, error-clear
 and lock pins. Assumes calls arrive just after a rising clock edge. */
`timescale 1ns/1ps
module sam_host_model #(
	parameter PULSE_MODE = 3'h0,
	parameter ENC_PULSES = 8192
) (
	input  wire clk,
	output reg  runIn,
	output reg  alarmResetIn,
	output reg  fwdTravelLimit,
	output reg  revTravelLimit,
	output reg  positionErrorClear,
	output reg  positionLockInput
);
	initial alarmResetIn = 1'h0;
	initial setPins(5'h1c);
	task setPins(input [4:0] p);
		{runIn, fwdTravelLimit, revTravelLimit, positionErrorClear, positionLockInput} = p;
	endtask
	task hold(input b);
		alarmResetIn = b;
	endtask
	// Whole rise and fall, so exactly one clearing edge is seen
	task pressReset(input integer n);
		alarmResetIn = 1'h1;
		repeat (n) @(posedge clk);
		#1 alarmResetIn = 1'h0;
	endtask
endmodule // sam_host_model

/* File: sam_overload.v */
/*
 Overload integrator: accumulates load excess over the rated level and
 leaks while below it. Trips once the sum reaches the budget for a three
 times rated load held for the trip time.
 Assumes load arrives as a synchronous percentage of rated current.
*/
`timescale 1ns/1ps
`include "sam_defines.vh"

module sam_overload #(
	parameter TRIP_CYCLES = (`SAM_TRIP_MS * `SAM_CLK_KHZ)
) (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire [`SAM_LOAD_W-1:0] loadPct,
	input  wire                   clear,
	output reg                    trip,
	output reg                    tripHigh
);
	// Budget: excess of 200 percent held for the trip time
	localparam [47:0] BUDGET = `SAM_TRIP_EXCESS * TRIP_CYCLES;
	reg  [47:0] heat;
	// Nine bits so that three times rated load is representable
	wire [`SAM_LOAD_W-1:0] excess = loadPct - `SAM_RATED_LOAD;
	wire        over   = loadPct > `SAM_RATED_LOAD;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			heat     <= 48'h0;
			trip     <= 1'b0;
			tripHigh <= 1'b0;
		end else if (clear) begin
			heat     <= 48'h0;
			// A trip reached in the clearing cycle wins over the clear
			trip     <= heat >= BUDGET && !trip;
			tripHigh <= loadPct > `SAM_HIGH_LOAD;
		end else begin
			if (over)
				heat <= heat + {39'h0, excess};
			else if (heat != 48'h0)
				heat <= heat - 48'h1;
			if (heat >= BUDGET && !trip) begin
				trip     <= 1'b1;
				tripHigh <= loadPct > `SAM_HIGH_LOAD;
			end
		end
	end
endmodule // sam_overload
